// >>> eeprom_device_end.sv
// Device end of the dual-mode serial EEPROM port: streaming mode at
// power-up, bidirectional two-wire target after the first SCL fall.
// Runs wholly on the link clock; the memory array sits outside and
// answers mem_rdata_in for mem_addr_out within one link clock.
`timescale 1ns/1ps
`default_nettype none

module eeprom_device_end
    import eeprom_link_pkg::*;
#(
    parameter int WRITE_CYCLES = `WRITE_CYCLES
)
(
    // Clock and reset
    input wire logic link_clk_in,
    input wire logic reset_in,
    // Link
    eeprom_link_if.device link,
    // Memory array
    output logic [6:0] mem_addr_out,
    input wire logic [7:0] mem_rdata_in,
    output logic wr_valid_out,
    output logic [6:0] wr_addr_out,
    output logic [7:0] wr_data_out,
    // Status
    output logic bidir_mode_out,
    output logic standby_out,
    output logic write_busy_out
);
    dev_s q;
    dev_s d;
    logic f_scl;
    logic f_sda;
    logic f_stream_clock_in;
    logic scl_rise;
    logic scl_fall;
    logic stream_clock_in_rise;
    logic start_seen;
    logic stop_seen;

    // ------------------------------------------------------------------
    // Pin conditioning
    // ------------------------------------------------------------------
    pin_filter scl_filter (
        .clk_in(link_clk_in),
        .reset_in(reset_in),
        .pin_in(link.scl),
        .level_out(f_scl)
    );

    pin_filter sda_filter (
        .clk_in(link_clk_in),
        .reset_in(reset_in),
        .pin_in(link.sda),
        .level_out(f_sda)
    );

    pin_filter stream_clock_in_filter (
        .clk_in(link_clk_in),
        .reset_in(reset_in),
        .pin_in(link.stream_clock),
        .level_out(f_stream_clock_in)
    );

    // Edges are taken from the filtered levels only.
    assign scl_rise = f_scl && !q.prev_scl;
    assign scl_fall = !f_scl && q.prev_scl;
    assign stream_clock_in_rise = f_stream_clock_in && !q.prev_stream_clock_in;
    // SDA moving while SCL stays high marks a start or a stop.
    assign start_seen = f_scl && q.prev_scl && q.prev_sda && !f_sda;
    assign stop_seen = f_scl && q.prev_scl && !q.prev_sda && f_sda;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        d.wr_valid = 1'b0;
        d.prev_scl = f_scl;
        d.prev_sda = f_sda;
        d.prev_stream_clock_in = f_stream_clock_in;
        if (!q.bidir) begin
            if (scl_fall) begin
                // No way back: only reset clears the bidirectional flag.
                d.bidir = 1'b1;
                d.oe = 1'b0;
                d.state = DS_IDLE;
                d.cnt = 4'd0;
            end else if (stream_clock_in_rise) begin
                if (q.init_cnt < `INIT_CLOCKS) begin
                    d.init_cnt = q.init_cnt + 4'd1;
                    d.oe = 1'b0;
                    if (q.init_cnt < `INIT_SAMPLE_CLOCKS) begin
                        d.hi_all = q.hi_all && f_sda;
                    end else begin
                        d.addr = q.hi_all ? `STREAM_ADDR_HIGH : `STREAM_ADDR_LOW;
                    end
                end else if (q.cnt == `WORD_BITS) begin
                    d.oe = 1'b0;
                    d.cnt = 4'd0;
                    d.addr = q.addr + 7'd1;
                end else begin
                    d.oe = !mem_rdata_in[3'd7 - q.cnt[2:0]];
                    d.cnt = q.cnt + 4'd1;
                end
            end
        end else if (q.state == DS_BUSY) begin
            // Inputs are ignored until the self-timed write is over.
            if (q.timer == `WRITE_TIMER_W'(WRITE_CYCLES - 1)) begin
                d.timer = '0;
                d.state = DS_IDLE;
            end else begin
                d.timer = q.timer + `WRITE_TIMER_W'(1);
            end
        end else if (start_seen) begin
            d.state = DS_RX;
            d.kind = WK_DEV;
            d.cnt = 4'd0;
            d.oe = 1'b0;
        end else if (stop_seen) begin
            d.oe = 1'b0;
            d.wrote = 1'b0;
            d.state = q.wrote ? DS_BUSY : DS_IDLE;
        end else begin
            case (q.state)
                DS_RX: begin
                    if (scl_rise && q.cnt < `WORD_BITS) begin
                        d.sh = {q.sh[6:0], f_sda};
                        d.cnt = q.cnt + 4'd1;
                    end else if (scl_fall && q.cnt == `WORD_BITS) begin
                        d.cnt = 4'd0;
                        d.oe = 1'b1;
                        d.state = DS_ACK;
                        case (q.kind)
                            WK_DEV: begin
                                // Bits 3..1 are don't-care device select bits.
                                if (q.sh[7:4] == `DEVICE_TYPE) begin
                                    d.rw = q.sh[0];
                                end else begin
                                    d.oe = 1'b0;
                                    d.state = DS_IDLE;
                                end
                            end
                            WK_WORD: begin
                                d.addr = q.sh[6:0];
                            end
                            default: begin
                                // A low stream clock pin write-protects the array.
                                if (f_stream_clock_in) begin
                                    d.wr_valid = 1'b1;
                                    d.wr_addr = q.addr;
                                    d.wr_data = q.sh;
                                    d.addr = {q.addr[6:3], q.addr[2:0] + 3'd1};
                                    d.wrote = 1'b1;
                                end
                            end
                        endcase
                    end
                end
                DS_ACK: begin
                    if (scl_fall) begin
                        if (q.kind == WK_DEV && q.rw) begin
                            d.state = DS_TX;
                            d.sh = mem_rdata_in;
                            d.oe = !mem_rdata_in[7];
                            d.cnt = 4'd0;
                        end else begin
                            d.oe = 1'b0;
                            d.state = DS_RX;
                            d.kind = (q.kind == WK_DEV) ? WK_WORD : WK_DATA;
                        end
                    end
                end
                DS_TX: begin
                    if (scl_fall) begin
                        if (q.cnt == 4'd7) begin
                            d.oe = 1'b0;
                            d.state = DS_MACK;
                            d.macked = 1'b0;
                            d.addr = q.addr + 7'd1;
                        end else begin
                            d.sh = {q.sh[6:0], 1'b0};
                            d.oe = !q.sh[6];
                            d.cnt = q.cnt + 4'd1;
                        end
                    end
                end
                DS_MACK: begin
                    if (scl_rise) begin
                        d.macked = !f_sda;
                    end else if (scl_fall) begin
                        if (q.macked) begin
                            d.state = DS_TX;
                            d.sh = mem_rdata_in;
                            d.oe = !mem_rdata_in[7];
                            d.cnt = 4'd0;
                        end else begin
                            d.state = DS_IDLE;
                        end
                    end
                end
                default: begin
                    d.oe = 1'b0;
                end
            endcase
        end
        d.standby = (d.state == DS_IDLE) && (d.bidir || d.init_cnt == 4'd0);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge link_clk_in) begin
        if (reset_in) begin
            q <= '0;
            q.bidir <= 1'b0;
            q.state <= DS_IDLE;
            q.kind <= WK_DEV;
            q.hi_all <= 1'b1;
            q.standby <= 1'b1;
            q.prev_scl <= 1'b1;
            q.prev_sda <= 1'b1;
            q.prev_stream_clock_in <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign link.sda_dev_o = 1'b0;
    assign link.sda_dev_oe = q.oe;
    assign mem_addr_out = q.addr;
    assign wr_valid_out = q.wr_valid;
    assign wr_addr_out = q.wr_addr;
    assign wr_data_out = q.wr_data;
    assign bidir_mode_out = q.bidir;
    assign standby_out = q.standby;
    assign write_busy_out = (q.state == DS_BUSY);
endmodule

`default_nettype wire

// >>> eeprom_link_map.svh
// Constants for the dual-mode serial EEPROM link: bit counts, address
// patterns and timing counts shared by both ends of the link.
// Assumes the host runs at 50 MHz and the device samples at the link clock.
//
// Operation
// - Power-up starts in streaming mode.
// - SCL falling edge locks bidirectional mode.
// - Stream one bit per clock, MSB first.
// - Ninth stream bit released, high impedance.
// - Stream addresses ascend, wrap 7FH to 00H.
// - Master holds SCL high while streaming.
// - No stream data before nine init clocks.
// - First eight clocks' SDA select start address.
// - Master releases SDA on ninth init clock.
// - Ignore stream clock; high enables writes.
// - SDA changes only while SCL low.
// - SDA fall, SCL high means start.
// - SDA rise, SCL high means stop.
// - Eight-bit words, device acks ninth clock.
// - Address word: type match, three ignored.
// - Last address bit selects read/write.
// - Match acks; mismatch returns to standby.
// - Standby at power-up and after stop.
// - Master recovers: nine clocks, then start. Host sends the start as soon as SDA reads high, after one to nine clocks.
// - Self-timed write ends within 10 ms.
`ifndef EEPROM_LINK_MAP_SVH
`define EEPROM_LINK_MAP_SVH

// ----------------------------------------------------------------------
// Word framing
// ----------------------------------------------------------------------
`define WORD_BITS 4'd8
`define INIT_CLOCKS 4'd9
`define INIT_SAMPLE_CLOCKS 4'd8
`define STREAM_ADDR_HIGH 7'h7F
`define STREAM_ADDR_LOW 7'h00
`define DEVICE_TYPE 4'hA

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define FILTER_LEN 2'd3
`define CLK_PERIOD_NS 20
`define T_LOW_NS 4700
`define QTR_CYCLES ((`T_LOW_NS / 2 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_TIME_US 10000
`define LINK_CLK_MHZ 166
`define WRITE_CYCLES (`WRITE_TIME_US * `LINK_CLK_MHZ)
`define WRITE_TIMER_W 21

`endif

// >>> eeprom_link_pkg.sv
// Types shared by both ends of the serial EEPROM link.
// Assumes the constant header sits in the same folder.
`include "eeprom_link_map.svh"

package eeprom_link_pkg;

    typedef enum logic [2:0] {
        DS_IDLE,
        DS_RX,
        DS_ACK,
        DS_TX,
        DS_MACK,
        DS_BUSY
    } dev_state_e;

    typedef enum logic [1:0] {
        WK_DEV,
        WK_WORD,
        WK_DATA
    } word_kind_e;

    typedef enum logic [2:0] {
        OP_START,
        OP_STOP,
        OP_WRITE,
        OP_READ,
        OP_RECOVER,
        OP_STREAM_INIT,
        OP_STREAM_WORD
    } host_op_e;

    typedef enum logic {
        HS_IDLE,
        HS_RUN
    } host_state_e;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic level;
        logic [1:0] cnt;
    } filt_s;

    typedef struct packed {
        logic bidir;
        dev_state_e state;
        word_kind_e kind;
        logic rw;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [6:0] addr;
        logic oe;
        logic [3:0] init_cnt;
        logic hi_all;
        logic wrote;
        logic macked;
        logic wr_valid;
        logic [6:0] wr_addr;
        logic [7:0] wr_data;
        logic standby;
        logic [`WRITE_TIMER_W-1:0] timer;
        logic prev_scl;
        logic prev_sda;
        logic prev_stream_clock_in;
    } dev_s;

    typedef struct packed {
        host_state_e st;
        host_op_e op;
        logic [3:0] bit_idx;
        logic [1:0] ph;
        logic [7:0] tick;
        logic [7:0] tx;
        logic [7:0] rx;
        logic ack_bit;
        logic ack_seen;
        logic scl;
        logic stream_clock_in;
        logic oe;
        logic done;
    } host_s;

endpackage

// >>> eeprom_link_if.sv
// Link between the EEPROM device end and the host end.
// SDA is a pulled-up wired line; each end gives an output and an enable.
`timescale 1ns/1ps
`default_nettype none

interface eeprom_link_if;
    logic scl;
    logic stream_clock;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic sda_host_o;
    logic sda_host_oe;
    wire logic sda;

    // Pull-up: the line is low only while an enabled end drives a zero.
    assign sda = !((sda_dev_oe && !sda_dev_o) || (sda_host_oe && !sda_host_o));

    modport device (
        input scl,
        input stream_clock,
        input sda,
        output sda_dev_o,
        output sda_dev_oe
    );

    modport host (
        output scl,
        output stream_clock,
        output sda_host_o,
        output sda_host_oe,
        input sda
    );
endinterface

`default_nettype wire

// >>> pin_filter.sv
// Two-flop synchroniser followed by a stability filter for one pin.
// Assumes the pin is idle high; the filtered level resets high.
`timescale 1ns/1ps
`default_nettype none

module pin_filter
    import eeprom_link_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Pin and filtered level
    input wire logic pin_in,
    output logic level_out
);
    filt_s q;
    filt_s d;

    // A new level is taken only after it has stood for the full filter
    // length, so short spikes never reach the edge detectors.
    always_comb begin
        d = q;
        d.sync1 = pin_in;
        d.sync2 = q.sync1;
        if (q.sync2 == q.level) begin
            d.cnt = 2'd0;
        end else if (q.cnt == `FILTER_LEN - 2'd1) begin
            d.level = q.sync2;
            d.cnt = 2'd0;
        end else begin
            d.cnt = q.cnt + 2'd1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            q <= '{sync1: 1'b1, sync2: 1'b1, level: 1'b1, cnt: 2'd0};
        end else begin
            q <= d;
        end
    end

    assign level_out = q.level;
endmodule

`default_nettype wire

// >>> eeprom_host_end.sv
// Host end of the link: master of SCL and the stream clock, both divided
// down from clk_in. Runs one command at a time: start, stop, byte write,
// byte read, bus recovery, stream initialisation and stream word.
`timescale 1ns/1ps
`default_nettype none

module eeprom_host_end
    import eeprom_link_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Link
    eeprom_link_if.host link,
    // Command
    input wire logic cmd_valid_in,
    input wire host_op_e cmd_op_in,
    input wire logic [7:0] cmd_data_in,
    input wire logic cmd_ack_in,
    output logic cmd_ready_out,
    // Result
    output logic done_out,
    output logic [7:0] rx_data_out,
    output logic ack_seen_out
);
    host_s q;
    host_s d;
    logic f_sda;
    logic qtr_end;

    pin_filter sda_filter (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .pin_in(link.sda),
        .level_out(f_sda)
    );

    // Level the host wants on SDA during one bit slot; one means release.
    function automatic logic bit_level(input host_op_e op, input logic [3:0] idx,
                                       input logic [7:0] tx, input logic ack_bit);
        logic v;
        v = 1'b1;
        if (op == OP_WRITE && idx < `WORD_BITS) begin
            v = tx[3'd7 - idx[2:0]];
        end else if (op == OP_READ && idx == `WORD_BITS) begin
            v = !ack_bit;
        end else if (op == OP_STREAM_INIT && idx < `INIT_SAMPLE_CLOCKS) begin
            v = tx[0];
        end
        return v;
    endfunction

    assign qtr_end = (q.tick == 8'(`QTR_CYCLES - 1));

    always_comb begin
        d = q;
        d.done = 1'b0;
        if (q.st == HS_IDLE) begin
            if (cmd_valid_in) begin
                d.st = HS_RUN;
                d.op = cmd_op_in;
                d.tx = cmd_data_in;
                d.ack_bit = cmd_ack_in;
                d.bit_idx = 4'd0;
                d.ph = 2'd0;
                d.tick = 8'd0;
            end
        end else if (!qtr_end) begin
            d.tick = q.tick + 8'd1;
        end else begin
            d.tick = 8'd0;
            d.ph = q.ph + 2'd1;
            if (q.ph == 2'd2) begin
                if (q.bit_idx < `WORD_BITS) begin
                    d.rx = {q.rx[6:0], f_sda};
                end else begin
                    d.ack_seen = !f_sda;
                end
                if (q.op == OP_RECOVER && f_sda) begin
                    d.op = OP_START;
                    d.bit_idx = 4'd0;
                    d.ph = 2'd0;
                end
            end else if (q.ph == 2'd3) begin
                if (q.op == OP_START || q.op == OP_STOP || q.bit_idx == `WORD_BITS) begin
                    d.st = HS_IDLE;
                    d.done = 1'b1;
                end else begin
                    d.bit_idx = q.bit_idx + 4'd1;
                end
            end
        end
        if (d.st == HS_RUN) begin
            case (d.op)
                OP_STREAM_INIT, OP_STREAM_WORD: begin
                    d.scl = 1'b1;
                    d.stream_clock_in = (d.ph == 2'd1 || d.ph == 2'd2);
                    d.oe = !bit_level(d.op, d.bit_idx, d.tx, d.ack_bit);
                end
                OP_START: begin
                    d.scl = (d.ph == 2'd1 || d.ph == 2'd2);
                    d.oe = (d.ph >= 2'd2);
                end
                OP_STOP: begin
                    d.scl = (d.ph != 2'd0);
                    d.oe = (d.ph < 2'd2);
                end
                default: begin
                    // Data moves only in phase 0, while SCL is low.
                    d.scl = (d.ph == 2'd1 || d.ph == 2'd2);
                    d.oe = !bit_level(d.op, d.bit_idx, d.tx, d.ack_bit);
                    d.stream_clock_in = (d.op == OP_WRITE) && d.ack_bit;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            q <= '0;
            q.st <= HS_IDLE;
            q.op <= OP_START;
            q.scl <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign link.scl = q.scl;
    assign link.stream_clock = q.stream_clock_in;
    assign link.sda_host_o = 1'b0;
    assign link.sda_host_oe = q.oe;
    assign cmd_ready_out = (q.st == HS_IDLE);
    assign done_out = q.done;
    assign rx_data_out = q.rx;
    assign ack_seen_out = q.ack_seen;
endmodule

`default_nettype wire

// >>> eeprom_link_sva.sv
// Checker for the wires that join the host end and the device end.
// Assumes one synchronous reset shared by the host and link clock domains.
`timescale 1ns/1ps
`default_nettype none

module eeprom_link_sva (
    // Clocks and reset
    input wire logic clk_in,
    input wire logic link_clk_in,
    input wire logic reset_in,
    // Link wires
    input wire logic scl,
    input wire logic stream_clock,
    input wire logic sda,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe,
    input wire logic sda_host_o,
    input wire logic sda_host_oe
);
    // ----------------------------------------------------------------
    // Helpers: SCL low seen, stream clock rises counted (saturating)
    // ----------------------------------------------------------------
    logic hb_q, hv_q, db_q, dv_q;
    logic [3:0] hn_q, dn_q;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            hb_q <= 1'b0;
            hv_q <= 1'b0;
            hn_q <= 4'h0;
        end else begin
            hb_q <= hb_q || !scl;
            hv_q <= stream_clock;
            if (stream_clock && !hv_q && hn_q != 4'hF) begin
                hn_q <= hn_q + 4'h1;
            end
        end
    end

    always_ff @(posedge link_clk_in) begin
        if (reset_in) begin
            db_q <= 1'b0;
            dv_q <= 1'b0;
            dn_q <= 4'h0;
        end else begin
            db_q <= db_q || !scl;
            dv_q <= stream_clock;
            if (stream_clock && !dv_q && dn_q != 4'hF) begin
                dn_q <= dn_q + 4'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    a_dev_open_drain: assert property (@(posedge link_clk_in) disable iff (reset_in) sda_dev_o == 1'b0)
        else $error("device drives sda high");
    a_host_open_drain: assert property (@(posedge clk_in) disable iff (reset_in) sda_host_o == 1'b0)
        else $error("host drives sda high");
    a_no_early_data: assert property (@(posedge link_clk_in) disable iff (reset_in)
        !db_q && dn_q <= 4'h9 |-> !sda_dev_oe) else $error("device drives sda before init ends");
    a_dev_moves_low: assert property (@(posedge link_clk_in) disable iff (reset_in)
        db_q && $changed(sda_dev_oe) |-> !scl) else $error("device moved sda with scl high");
    a_scl_held_stream: assert property (@(posedge clk_in) disable iff (reset_in)
        !hb_q && stream_clock |-> scl) else $error("scl low during stream clock");
    a_init_release: assert property (@(posedge clk_in) disable iff (reset_in)
        !hb_q && stream_clock && hn_q == 4'h9 |-> !sda_host_oe) else $error("host drives ninth init clock");
    a_start_from_high: assert property (@(posedge clk_in) disable iff (reset_in)
        hb_q && scl && $past(scl) && $rose(sda_host_oe) |-> $past(sda)) else $error("start without sda high");
    a_stop_scl_high: assert property (@(posedge clk_in) disable iff (reset_in)
        hb_q && scl && $past(scl) && $fell(sda_host_oe) |=> scl [*8]) else $error("scl dropped after stop");
endmodule

`default_nettype wire

// >>> dual_mode_serial_eeprom_port_bench.sv
// Bench joining the host end and the device end face to face.
// Assumes the memory array answers within one link clock; writes shortened.
`timescale 1ns/1ps
`default_nettype none

module dual_mode_serial_eeprom_port_bench import eeprom_link_pkg::*;;
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
    // ----------------------------------------------------------------
    // Clocks, memory array and the two ends
    // ----------------------------------------------------------------
    logic clk_in = 1'b0;
    logic link_clk = 1'b0;
    logic reset_in = 1'b1;
    logic cmd_valid = 1'b0;
    host_op_e cmd_op = OP_START;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_ack = 1'b0;
    logic cmd_ready, done, ack_seen, bidir, standby, busy, wr_valid;
    logic [7:0] rx_data, rdata, wr_data;
    logic [6:0] mem_addr, wr_addr;
    logic [7:0] mem [128];
    int num_errors = 0;
    int n_compared = 0;
    int wr_cnt = 0;
    int cyc = 0;

    always #10 clk_in = !clk_in;
    always #3 link_clk = !link_clk;

    function automatic logic [7:0] pat(input int a);
        return 8'(a * 7 + 3);
    endfunction

    assign rdata = mem[mem_addr];
    always @(posedge link_clk) begin
        if (wr_valid === 1'b1) begin
            mem[wr_addr] <= wr_data;
            wr_cnt++;
        end
    end

    eeprom_link_if eeprom_link_if_i ();
    eeprom_device_end #(.WRITE_CYCLES(50)) eeprom_device_end_i (.link_clk_in(link_clk), .reset_in(reset_in),
        .link(eeprom_link_if_i.device), .mem_addr_out(mem_addr), .mem_rdata_in(rdata), .wr_valid_out(wr_valid),
        .wr_addr_out(wr_addr), .wr_data_out(wr_data), .bidir_mode_out(bidir), .standby_out(standby),
        .write_busy_out(busy));
    eeprom_host_end eeprom_host_end_i (.clk_in(clk_in), .reset_in(reset_in), .link(eeprom_link_if_i.host),
        .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op), .cmd_data_in(cmd_data), .cmd_ack_in(cmd_ack),
        .cmd_ready_out(cmd_ready), .done_out(done), .rx_data_out(rx_data), .ack_seen_out(ack_seen));
    eeprom_link_sva eeprom_link_sva_i (.clk_in(clk_in), .link_clk_in(link_clk), .reset_in(reset_in),
        .scl(eeprom_link_if_i.scl), .stream_clock(eeprom_link_if_i.stream_clock), .sda(eeprom_link_if_i.sda),
        .sda_dev_o(eeprom_link_if_i.sda_dev_o), .sda_dev_oe(eeprom_link_if_i.sda_dev_oe),
        .sda_host_o(eeprom_link_if_i.sda_host_o), .sda_host_oe(eeprom_link_if_i.sda_host_oe));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // A hung command must not stall the run past the longest expected sequence.
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 90000) begin
            num_errors++;
            conclude();
        end
    end

    task automatic do_reset();
        reset_in <= 1'b1;
        repeat (20) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic cmd(input host_op_e op, input logic [7:0] d, input logic a);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 5000) begin
            @(posedge clk_in);
            n++;
        end
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_data <= d;
        cmd_ack <= a;
        @(posedge clk_in);
        cmd_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (done !== 1'b1 && n < 5000);
        `CHK("done", 1'b1, done)
    endtask

    task automatic wr(input logic [7:0] d, input logic e);
        cmd(OP_WRITE, d, 1'b0);
        `CHK("ack", e, ack_seen)
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_stream_low();
        do_reset();
        `CHK("bidir", 1'b0, bidir)
        `CHK("standby", 1'b1, standby)
        cmd(OP_STREAM_INIT, 8'h00, 1'b0);
        cmd(OP_STREAM_WORD, 8'h00, 1'b0);
        `CHK("word0", pat(0), rx_data)
        `CHK("ninth", 1'b0, ack_seen)
        $display("stream low finished");
    endtask

    task automatic t_stream_wrap();
        do_reset();
        cmd(OP_STREAM_INIT, 8'h01, 1'b0);
        cmd(OP_STREAM_WORD, 8'h00, 1'b0);
        `CHK("word7f", pat(127), rx_data)
        cmd(OP_STREAM_WORD, 8'h00, 1'b0);
        `CHK("wrap", pat(0), rx_data)
        `CHK("stay", 1'b0, bidir)
        $display("stream wrap finished");
    endtask

    task automatic t_write_locked();
        cmd(OP_START, 8'h00, 1'b0);
        `CHK("bidir", 1'b1, bidir)
        wr(8'hA0, 1'b1);
        wr(8'h24, 1'b1);
        wr(8'h5A, 1'b1);
        cmd(OP_WRITE, 8'hC3, 1'b1);
        cmd(OP_STOP, 8'h00, 1'b0);
        `CHK("writes", 1, wr_cnt)
        `CHK("busy", 1'b0, busy)
        `CHK("standby", 1'b1, standby)
        $display("write finished");
    endtask

    task automatic t_mismatch();
        cmd(OP_START, 8'h00, 1'b0);
        wr(8'h50, 1'b0);
        cmd(OP_STOP, 8'h00, 1'b0);
        `CHK("idle", 1'b1, standby)
        $display("address mismatch finished");
    endtask

    task automatic t_random_read();
        cmd(OP_START, 8'h00, 1'b0);
        wr(8'hA0, 1'b1);
        wr(8'h23, 1'b1);
        cmd(OP_START, 8'h00, 1'b0);
        wr(8'hAF, 1'b1);
        cmd(OP_READ, 8'h00, 1'b1);
        `CHK("read", pat(8'h23), rx_data)
        cmd(OP_READ, 8'h00, 1'b0);
        `CHK("seq", 8'hC3, rx_data)
        cmd(OP_STOP, 8'h00, 1'b0);
        $display("random read finished");
    endtask

    task automatic t_recover();
        cmd(OP_RECOVER, 8'h00, 1'b0);
        wr(8'hA0, 1'b1);
        cmd(OP_STOP, 8'h00, 1'b0);
        $display("bus recovery finished");
    endtask

    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = pat(i);
        end
        t_stream_low();
        t_stream_wrap();
        t_write_locked();
        t_mismatch();
        t_random_read();
        t_recover();
        conclude();
    end
endmodule

`default_nettype wire
